// ==== hw/gex_port_control.v ====
// Port control, serial register access and input interrupt logic of the GPIO expander
`include "gex_defines.vh"

module gex_port_control #(
    parameter                 CNT_W    = 7,
    parameter [CNT_W-1:0]     FILT_CYC = `GEX_FILTER_CYC
) (
    // System
    input  wire               clk,
    input  wire               rst,
    input  wire               ce,
    // Serial register link
    input  wire               sclk,
    input  wire               csN,
    input  wire               mosi,
    output reg                miso,
    output reg                misoOe,
    // Pins
    input  wire [7:0]         gpioIn,
    output reg  [7:0]         gpioOut,
    output reg  [7:0]         gpioOe,
    output reg  [7:0]         pullupOn,
    // Interrupt, open drain
    output reg                irqOut,
    output reg                irqOe
);

    // ****************************************************************
    // Link states
    // ****************************************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CMD  = 3'b010;
    localparam [2:0] ST_DATA = 3'b100;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wire                      sclkS;
    wire                      csNS;
    wire                      mosiS;
    wire [7:0]                pinS;
    wire [7:0]                filtQ;
    wire [7:0]                fin;
    wire [7:0]                riseHit;
    wire [7:0]                fallHit;
    wire [7:0]                bothMode;
    wire [7:0]                edgeHit;
    wire [7:0]                setIrq;
    wire [7:0]                clrIrq;
    wire [7:0]                next_status;
    wire [7:0]                inByte;
    wire                      sclkRise;
    wire                      sclkFall;

    reg                       sclkD;
    reg  [2:0]                state;
    reg  [2:0]                bitCnt;
    reg  [7:0]                shiftIn;
    reg  [7:0]                shiftOut;
    reg                       cmdRead;
    reg  [6:0]                cmdAddr;
    reg                       rdPinState;

    reg  [7:0]                outLevel;
    reg  [7:0]                pinDirection;
    reg  [7:0]                pullupEnable;
    reg  [7:0]                irqEnable;
    reg  [7:0]                hizControl;
    reg  [7:0]                irqStatus;
    reg  [7:0]                riseEnable;
    reg  [7:0]                fallEnable;
    reg  [7:0]                filterEnable;
    reg  [7:0]                finD;
    reg  [7:0]                snap;

    // ****************************************************************
    // Read decode
    // ****************************************************************
    function [7:0] regRead;
        input [6:0] addr;
        begin
            case (addr)
                `GEX_ADDR_PIN_STATE:     regRead = (pinDirection & pinS) | (~pinDirection & outLevel);
                `GEX_ADDR_OUTPUT_LEVEL:  regRead = outLevel;
                `GEX_ADDR_PIN_DIRECTION: regRead = pinDirection;
                `GEX_ADDR_PULLUP_ENABLE: regRead = pullupEnable;
                `GEX_ADDR_IRQ_ENABLE:    regRead = irqEnable;
                `GEX_ADDR_HIZ_CONTROL:   regRead = hizControl;
                `GEX_ADDR_IRQ_STATUS:    regRead = irqStatus;
                `GEX_ADDR_RISE_ENABLE:   regRead = riseEnable;
                `GEX_ADDR_FALL_ENABLE:   regRead = fallEnable;
                `GEX_ADDR_FILTER_ENABLE: regRead = filterEnable;
                default:                 regRead = 8'h00;
            endcase
        end
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    gex_sync #(
        .W       (3),
        .RST_VAL (3'b010)
    ) uLinkSync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   ({sclk, csN, mosi}),
        .q   ({sclkS, csNS, mosiS})
    );

    // Bit n of every vector is pin n throughout
    gex_sync #(
        .W       (8),
        .RST_VAL (8'h00)
    ) uPinSync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   (gpioIn),
        .q   (pinS)
    );

    // ****************************************************************
    // Glitch filters
    // ****************************************************************
    // Threshold sits mid-window so both limits keep margin
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : gFilt
            gex_glitch_filter #(
                .CNT_W  (CNT_W),
                .CYCLES (FILT_CYC)
            ) uFilt (
                .clk (clk),
                .rst (rst),
                .ce  (ce),
                .d   (pinS[gi]),
                .q   (filtQ[gi])
            );
        end
    endgenerate

    assign fin = (filterEnable & filtQ) | (~filterEnable & pinS);

    // ****************************************************************
    // Edge detection and interrupt status
    // ****************************************************************
    assign riseHit     = fin & ~finD;
    assign fallHit     = ~fin & finD;
    assign bothMode    = ~riseEnable & ~fallEnable;
    assign edgeHit     = (riseHit & (riseEnable | bothMode))
                       | (fallHit & (fallEnable | bothMode));
    assign setIrq      = pinDirection & irqEnable & edgeHit;
    assign clrIrq      = {8{rdPinState}}
                       | (bothMode & ~(fin ^ snap));
    // A new edge in the clearing cycle survives
    assign next_status = (irqStatus & ~clrIrq) | setIrq;

    always @(posedge clk) begin
        if (rst) begin
            finD      <= 8'h00;
            snap      <= 8'h00;
            irqStatus <= `GEX_RST_IRQ_STATUS;
        end else if (ce) begin
            finD      <= fin;
            irqStatus <= next_status;
            if (rdPinState) begin
                snap <= fin;
            end
        end
    end

    // ****************************************************************
    // Serial link: mode 0, command byte then data byte
    // ****************************************************************
    assign sclkRise = ~csNS & sclkS & ~sclkD;
    assign sclkFall = ~csNS & ~sclkS & sclkD;
    assign inByte   = {shiftIn[6:0], mosiS};

    always @(posedge clk) begin
        if (rst) begin
            sclkD        <= 1'b0;
            state        <= ST_IDLE;
            bitCnt       <= 3'h0;
            shiftIn      <= 8'h00;
            shiftOut     <= 8'h00;
            cmdRead      <= 1'b0;
            cmdAddr      <= 7'h00;
            rdPinState   <= 1'b0;
            outLevel     <= `GEX_RST_OUTPUT_LEVEL;
            pinDirection <= `GEX_RST_PIN_DIRECTION;
            pullupEnable <= `GEX_RST_PULLUP_ENABLE;
            irqEnable    <= `GEX_RST_IRQ_ENABLE;
            hizControl   <= `GEX_RST_HIZ_CONTROL;
            riseEnable   <= `GEX_RST_RISE_ENABLE;
            fallEnable   <= `GEX_RST_FALL_ENABLE;
            filterEnable <= `GEX_RST_FILTER_ENABLE;
        end else if (ce) begin
            sclkD      <= sclkS;
            rdPinState <= 1'b0;
            case (state)
                ST_IDLE: begin
                    bitCnt   <= 3'h0;
                    shiftOut <= 8'h00;
                    if (!csNS) begin
                        state <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (csNS) begin
                        state <= ST_IDLE;
                    end else if (sclkRise) begin
                        shiftIn <= inByte;
                        bitCnt  <= bitCnt + 1'b1;
                        if (bitCnt == `GEX_LAST_BIT) begin
                            cmdRead  <= inByte[`GEX_CMD_READ_BIT];
                            cmdAddr  <= inByte[6:0];
                            state    <= ST_DATA;
                            if (inByte[`GEX_CMD_READ_BIT]) begin
                                shiftOut   <= regRead(inByte[6:0]);
                                rdPinState <= (inByte[6:0] == `GEX_ADDR_PIN_STATE);
                            end
                        end
                    end else if (sclkFall) begin
                        shiftOut <= {shiftOut[6:0], 1'b0};
                    end
                end
                ST_DATA: begin
                    if (csNS) begin
                        state <= ST_IDLE;
                    end else if (sclkRise) begin
                        shiftIn <= inByte;
                        bitCnt  <= bitCnt + 1'b1;
                        if (bitCnt == `GEX_LAST_BIT) begin
                            state <= ST_CMD;
                            if (!cmdRead) begin
                                // Status and pin state ignore writes
                                case (cmdAddr)
                                    `GEX_ADDR_OUTPUT_LEVEL:  outLevel     <= inByte;
                                    `GEX_ADDR_PIN_DIRECTION: pinDirection <= inByte;
                                    `GEX_ADDR_PULLUP_ENABLE: pullupEnable <= inByte;
                                    `GEX_ADDR_IRQ_ENABLE:    irqEnable    <= inByte;
                                    `GEX_ADDR_HIZ_CONTROL:   hizControl   <= inByte;
                                    `GEX_ADDR_RISE_ENABLE:   riseEnable   <= inByte;
                                    `GEX_ADDR_FALL_ENABLE:   fallEnable   <= inByte;
                                    `GEX_ADDR_FILTER_ENABLE: filterEnable <= inByte;
                                    default: begin
                                    end
                                endcase
                            end
                        end
                    end else if (sclkFall) begin
                        shiftOut <= {shiftOut[6:0], 1'b0};
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Sampled link clock lags the pin by up to three cycles; fine at 8 MHz
    always @(posedge clk) begin
        if (rst) begin
            miso     <= 1'b0;
            misoOe   <= 1'b0;
            gpioOut  <= `GEX_RST_OUTPUT_LEVEL;
            gpioOe   <= 8'h00;
            pullupOn <= 8'h00;
            irqOut   <= 1'b0;
            irqOe    <= 1'b0;
        end else if (ce) begin
            misoOe   <= ~csNS;
            if (sclkFall) begin
                miso <= shiftOut[7];
            end
            gpioOut  <= outLevel;
            gpioOe   <= ~pinDirection & ~hizControl;
            pullupOn <= pullupEnable & pinDirection;
            irqOut   <= 1'b0;
            irqOe    <= |irqStatus;
        end
    end

endmodule

// ==== common/gex_defines.vh ====
// Shared constants of the GPIO expander port control block
`ifndef GEX_DEFINES_VH
`define GEX_DEFINES_VH

// ****************************************************************
// Register offsets (seven-bit address of the command byte)
// ****************************************************************
`define GEX_ADDR_PIN_STATE      7'h00
`define GEX_ADDR_OUTPUT_LEVEL   7'h01
`define GEX_ADDR_PIN_DIRECTION  7'h03
`define GEX_ADDR_PULLUP_ENABLE  7'h04
`define GEX_ADDR_IRQ_ENABLE     7'h05
`define GEX_ADDR_HIZ_CONTROL    7'h06
`define GEX_ADDR_IRQ_STATUS     7'h07
`define GEX_ADDR_RISE_ENABLE    7'h08
`define GEX_ADDR_FALL_ENABLE    7'h09
`define GEX_ADDR_FILTER_ENABLE  7'h0A

// ****************************************************************
// Reset values
// ****************************************************************
`define GEX_RST_OUTPUT_LEVEL    8'h00
`define GEX_RST_PIN_DIRECTION   8'hFF
`define GEX_RST_PULLUP_ENABLE   8'h00
`define GEX_RST_IRQ_ENABLE      8'h00
`define GEX_RST_HIZ_CONTROL     8'h00
`define GEX_RST_IRQ_STATUS      8'h00
`define GEX_RST_RISE_ENABLE     8'h00
`define GEX_RST_FALL_ENABLE     8'h00
`define GEX_RST_FILTER_ENABLE   8'hFF

// ****************************************************************
// Command byte fields
// ****************************************************************
`define GEX_CMD_READ_BIT        7
`define GEX_LAST_BIT            3'h7

// ****************************************************************
// Timing
// ****************************************************************
`define GEX_CLK_MHZ             100
`define GEX_REJECT_NS           225
`define GEX_ACCEPT_NS           1075
`define GEX_FILTER_NS           650
// 650 ns at 100 MHz, sized for the seven-bit filter counter
`define GEX_FILTER_CYC          7'h41

`endif

// ==== hw/gex_sync.v ====
// Two-stage synchroniser for a group of asynchronous inputs
module gex_sync #(
    parameter             W       = 1,
    parameter [W-1:0]     RST_VAL = {W{1'b0}}
) (
    // System
    input  wire           clk,
    input  wire           rst,
    input  wire           ce,
    // Data
    input  wire [W-1:0]   d,
    output reg  [W-1:0]   q
);

    reg [W-1:0] meta;

    // First stage feeds the second stage only
    always @(posedge clk) begin
        if (rst) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ==== hw/gex_glitch_filter.v ====
// Glitch filter for one input: a level must hold CYCLES clocks to pass
module gex_glitch_filter #(
    parameter                 CNT_W  = 7,
    parameter [CNT_W-1:0]     CYCLES = 7'h41
) (
    // System
    input  wire               clk,
    input  wire               rst,
    input  wire               ce,
    // Data
    input  wire               d,
    output reg                q
);

    reg [CNT_W-1:0] cnt;

    // ****************************************************************
    // Disagreement counter
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            q   <= 1'b0;
            cnt <= {CNT_W{1'b0}};
        end else if (ce) begin
            if (d == q) begin
                cnt <= {CNT_W{1'b0}};
            end else if (cnt == CYCLES - 1'b1) begin
                q   <= d;
                cnt <= {CNT_W{1'b0}};
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

endmodule

// ==== test/gex_port_control_assertions.sv ====
// Concurrent checks on the pins of the port control block
// ********
// Checker
// ********
module gex_port_control_assertions #(
    parameter             CNT_W    = 7,
    parameter [CNT_W-1:0] FILT_CYC = 7'd65
) (
    // System
    input logic       clk,
    input logic       rst,
    input logic       ce,
    // Serial link
    input logic       sclk,
    input logic       csN,
    input logic       mosi,
    input logic       miso,
    input logic       misoOe,
    // Pins
    input logic [7:0] gpioIn,
    input logic [7:0] gpioOut,
    input logic [7:0] gpioOe,
    input logic [7:0] pullupOn,
    // Interrupt
    input logic       irqOut,
    input logic       irqOe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] prevIn;
    logic [7:0] quietCnt;
    logic [7:0] idleCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Saturating ages, so long idle spans never wrap into a false pass
    always @(posedge clk) begin
        prevIn <= gpioIn;
        if (rst) begin
            quietCnt <= 8'hFF;
            idleCnt  <= 8'hFF;
        end else begin
            quietCnt <= (gpioIn != prevIn) ? 8'h00 : quietCnt + {7'h00, quietCnt != 8'hFF};
            idleCnt  <= csN ? idleCnt + {7'h00, idleCnt != 8'hFF} : 8'h00;
        end
    end
    property p_reset_state; $fell(rst) |-> gpioOe == 8'h00 && pullupOn == 8'h00 && !irqOe && !misoOe; endproperty
    a_reset_state: assert property (p_reset_state) else $error("outputs not in reset state");
    property p_pull_inputs; (pullupOn & gpioOe) == 8'h00; endproperty
    a_pull_inputs: assert property (p_pull_inputs) else $error("pull-up on a driven pin");
    property p_irq_pin; irqOe |-> !irqOut; endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt line driven high");
    property p_irq_cause; $rose(irqOe) |-> quietCnt < FILT_CYC + 8'd16; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without pin change");
    property p_irq_clear; $fell(irqOe) |-> idleCnt < 8'd40 || quietCnt < FILT_CYC + 8'd16; endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt cleared without cause");
    property p_cfg_frame; $changed(gpioOe) || $changed(gpioOut) || $changed(pullupOn) |-> idleCnt < 8'd24; endproperty
    a_cfg_frame: assert property (p_cfg_frame) else $error("pin setup changed outside a frame");
    property p_oe_on; !csN [*4] |=> misoOe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data out not enabled in frame");
    property p_oe_off; csN [*4] |=> !misoOe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("data out enabled while deselected");
    property p_miso_shift; $changed(miso) |-> !sclk; endproperty
    a_miso_shift: assert property (p_miso_shift) else $error("data out moved while link clock high");
endmodule

bind gex_port_control gex_port_control_assertions #(.CNT_W(CNT_W), .FILT_CYC(FILT_CYC)) u_chk (
    .clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
    .misoOe(misoOe), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .pullupOn(pullupOn), .irqOut(irqOut), .irqOe(irqOe)
);

// ==== test/gex_spi_host.sv ====
// Serial host model that reaches the block's registers
module gex_spi_host (
    // Link
    output logic sclk,
    output logic csN,
    output logic mosi,
    input  logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Half of the 125 ns link clock
    localparam real HALF = 62.5;
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end
    // Command byte then data byte, mode 0; clock stands low between frames
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
        logic [15:0] frm;
        frm  = {cmd, wdat};
        rdat = 8'h00;
        // Odd start offset keeps link edges clear of system clock edges
        #3 csN <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi <= frm[i];
            #(HALF);
            if (i < 8) rdat[i] = miso;
            sclk <= 1'b1;
            #(HALF);
            sclk <= 1'b0;
        end
        #(HALF);
        csN <= 1'b1;
        // Released line shows the inverse, not a stale bit
        mosi <= ~mosi;
        #100;
    endtask
endmodule

// ==== test/gex_port_control_tb.sv ====
// Self-checking bench for the port control block
`include "gex_defines.vh"
module gex_port_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk;
    logic       rst;
    logic       ce;
    logic [7:0] gpioIn;
    wire        sclk, csN, mosi, miso, misoOe, irqOut, irqOe;
    wire  [7:0] gpioOut, gpioOe, pullupOn;
    int         miscompares = 0;
    int         cmpCount = 0;
    gex_port_control dut (
        .clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .csN(csN), .mosi(mosi),
        .miso(miso), .misoOe(misoOe), .gpioIn(gpioIn), .gpioOut(gpioOut),
        .gpioOe(gpioOe), .pullupOn(pullupOn), .irqOut(irqOut), .irqOe(irqOe)
    );
    gex_spi_host host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ********
    // Helpers
    // ********
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer({1'b0, a}, d, r);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        host.xfer({1'b1, a}, 8'h00, d);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check(v, e);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        logic [6:0] adr [9] = '{`GEX_ADDR_PIN_DIRECTION, `GEX_ADDR_PULLUP_ENABLE, `GEX_ADDR_IRQ_ENABLE,
            `GEX_ADDR_HIZ_CONTROL, `GEX_ADDR_IRQ_STATUS, `GEX_ADDR_RISE_ENABLE, `GEX_ADDR_FALL_ENABLE,
            `GEX_ADDR_FILTER_ENABLE, 7'h0F};
        logic [7:0] exp [9] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
        for (int i = 0; i < 9; i++) rd_chk(adr[i], exp[i]);
        check(gpioOe, 8'h00);
        check(pullupOn, 8'h00);
        check({7'h00, irqOe}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_config();
        wr(`GEX_ADDR_OUTPUT_LEVEL, 8'hC3);
        wr(`GEX_ADDR_HIZ_CONTROL, 8'h30);
        wr(`GEX_ADDR_PULLUP_ENABLE, 8'hFF);
        wr(`GEX_ADDR_PIN_DIRECTION, 8'h0F);
        wait_clk(2);
        check(gpioOe, 8'hC0);
        check(gpioOut, 8'hC3);
        check(pullupOn, 8'h0F);
        rd_chk(`GEX_ADDR_HIZ_CONTROL, 8'h30);
        // Status is read-only: the write must leave it clear
        wr(`GEX_ADDR_IRQ_STATUS, 8'hFF);
        rd_chk(`GEX_ADDR_IRQ_STATUS, 8'h00);
        wr(`GEX_ADDR_PIN_DIRECTION, 8'hFF);
        wr(`GEX_ADDR_PULLUP_ENABLE, 8'h00);
        wait_clk(2);
        check(gpioOe, 8'h00);
        $display("test config done");
    endtask
    task automatic ev(input logic [7:0] ien, re, fe, dir, from, to, exp);
        logic [7:0] v;
        wr(`GEX_ADDR_IRQ_ENABLE, ien);
        wr(`GEX_ADDR_RISE_ENABLE, re);
        wr(`GEX_ADDR_FALL_ENABLE, fe);
        wr(`GEX_ADDR_PIN_DIRECTION, dir);
        @(posedge clk);
        gpioIn <= from;
        wait_clk(20);
        // Clears leftovers and takes the snapshot
        rd(`GEX_ADDR_PIN_STATE, v);
        check(v, (dir & from) | (~dir & 8'hC3));
        @(posedge clk);
        gpioIn <= to;
        wait_clk(10);
        rd_chk(`GEX_ADDR_IRQ_STATUS, exp);
        check({7'h00, irqOe}, {7'h00, |exp});
    endtask
    task automatic t_edges();
        wr(`GEX_ADDR_FILTER_ENABLE, 8'h00);
        ev(8'hFF, 8'h01, 8'h00, 8'hFF, 8'h00, 8'h01, 8'h01);
        ev(8'hFF, 8'h01, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h00);
        ev(8'hFF, 8'h00, 8'h80, 8'hFF, 8'h80, 8'h00, 8'h80);
        ev(8'hFF, 8'h00, 8'h80, 8'hFF, 8'h00, 8'h80, 8'h00);
        ev(8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h81, 8'h81);
        ev(8'hFF, 8'h00, 8'h00, 8'hFF, 8'h81, 8'h00, 8'h81);
        ev(8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h00, 8'hFF, 8'h7F);
        ev(8'h7E, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h7E);
        ev(8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h04, 8'h04);
        @(posedge clk);
        gpioIn <= 8'h00;
        wait_clk(10);
        rd_chk(`GEX_ADDR_IRQ_STATUS, 8'h00);
        check({7'h00, irqOe}, 8'h00);
        $display("test edges done");
    endtask
    task automatic pulse(input int n);
        @(posedge clk);
        gpioIn <= 8'h01;
        wait_clk(n);
        gpioIn <= 8'h00;
        wait_clk(100);
    endtask
    task automatic t_filter();
        logic [7:0] v;
        wr(`GEX_ADDR_FILTER_ENABLE, 8'hFF);
        wr(`GEX_ADDR_RISE_ENABLE, 8'h01);
        wr(`GEX_ADDR_FALL_ENABLE, 8'h00);
        wr(`GEX_ADDR_IRQ_ENABLE, 8'h01);
        wait_clk(100);
        rd(`GEX_ADDR_PIN_STATE, v);
        pulse(22);
        rd_chk(`GEX_ADDR_IRQ_STATUS, 8'h00);
        pulse(108);
        rd_chk(`GEX_ADDR_IRQ_STATUS, 8'h01);
        $display("test filter done");
    endtask
    task automatic t_hold();
        logic [7:0] v;
        wr(`GEX_ADDR_FILTER_ENABLE, 8'h00);
        wr(`GEX_ADDR_RISE_ENABLE, 8'h00);
        rd(`GEX_ADDR_PIN_STATE, v);
        @(posedge clk);
        ce <= 1'b0;
        gpioIn <= 8'h01;
        wait_clk(20);
        // Frozen clock enable must hold back the new edge
        check({7'h00, irqOe}, 8'h00);
        ce <= 1'b1;
        wait_clk(10);
        check({7'h00, irqOe}, 8'h01);
        rd_chk(`GEX_ADDR_IRQ_STATUS, 8'h01);
        $display("test hold done");
    endtask
    task automatic t_midreset();
        @(posedge clk);
        rst <= 1'b1;
        wait_clk(4);
        rst <= 1'b0;
        wait_clk(2);
        check({7'h00, irqOe}, 8'h00);
        check(gpioOe, 8'h00);
        rd_chk(`GEX_ADDR_PIN_DIRECTION, 8'hFF);
        rd_chk(`GEX_ADDR_FILTER_ENABLE, 8'hFF);
        rd_chk(`GEX_ADDR_IRQ_STATUS, 8'h00);
        $display("test mid-run reset done");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        gpioIn = 8'h00;
        wait_clk(4);
        rst <= 1'b0;
        wait_clk(2);
        t_reset();
        t_config();
        t_edges();
        t_filter();
        t_hold();
        t_midreset();
        print_verdict();
    end
    // About twice the expected run length
    initial begin
        #400000;
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
